// ===== rtl/bma_top.sv
// External memory interface: wait states, memory selects and byte-memory DMA engine
`timescale 1ns/1ps
// Functional notes
// - Up to 15 wait states inserted per each of four I/O regions.
// - I/O wait field chosen by address bits 10:9, four 512-word regions.
// - Mode bit set gives 2N+1 wait states, held within 0..15.
// - Full mode drives all address lines; host mode drives only A0.
// - Composite select asserts when any enabled individual select asserts.
// - Composite select shares select timing and bus-release behaviour.
// - Reset sets all composite enables except the byte-select bit.
// - Byte space is 256 pages of 16K bytes, read and write.
// - Byte data travels on data lines 15 to 8.
// - Byte address: page on data 23:16, offset on address 13:0.
// - Byte accesses timed by byte wait count and mode bit.
// - Engine runs beside the core, one on-chip cycle per word.
// - Engine does as many byte accesses as the word format needs.
// - Format 00 24-bit program, 01 16-bit data, 10 8-bit high.
// - Format 11 8-bit low; unused bits of 8-bit formats are zero.
// - Nonzero word count write starts engine, runs until count zero.
// - Completion pulse once the programmed number of words is done.
// - Core external accesses win over pending engine byte accesses.
module bma_top
    import bma_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          reg_en,
    input  wire logic          reg_we,
    input  wire logic [13:0]   reg_addr,
    input  wire logic [15:0]   reg_wdata,
    output logic [15:0]        reg_rdata,
    input  wire logic          core_req,
    input  wire bma_ext_req_t  core_cmd,
    output logic               core_ack,
    output logic [23:0]        core_rdata,
    input  wire logic          host_mode,
    input  wire logic          bus_req_n,
    output logic               bus_grant_n,
    output logic [13:0]        addr_o,
    output logic               addr_lo_oe_n,
    output logic               addr_hi_oe_n,
    output logic [23:0]        data_o,
    input  wire logic [23:0]   data_i,
    output logic [2:0]         data_oe_n,
    output logic               ctrl_oe_n,
    output logic               rd_n,
    output logic               wr_n,
    output logic               pms_n,
    output logic               dms_n,
    output logic               bms_n,
    output logic               io_space_select_n,
    output logic               cms_n,
    output logic               mem_wr_valid,
    input  wire logic          mem_wr_ready,
    output bma_mem_word_t      mem_wr_word,
    output logic               mem_rd_valid,
    input  wire logic          mem_rd_ready,
    output logic [14:0]        mem_rd_addr,
    input  wire logic [23:0]   mem_rd_data,
    output logic               byte_transfer_engine_busy,
    output logic               byte_transfer_engine_done
);
    typedef enum logic [1:0] {
        E_IDLE  = 2'b00,
        E_FETCH = 2'b01,
        E_BYTES = 2'b10,
        E_PUSH  = 2'b11
    } bma_eng_t;

    // Pin synchronisers
    logic [23:0] din_s1_r, din_s2_r;
    logic [1:0]  host_s_r, breq_s_r;
    // Registers
    logic [15:0] sysctl_r, iowait_r, bctl_r;
    logic [3:0]  cmsen_r;
    logic [7:0]  page_r;
    logic [13:0] int_addr_r, ext_addr_r, wcount_r;
    logic [15:0] reg_rdata_r;
    // Access machine
    logic        act_r, act_core_r, grant_r;
    logic [3:0]  sel_r;
    logic        rd_r, wr_r;
    logic [13:0] addr_r;
    logic [23:0] dout_r;
    logic [2:0]  lane_oe_n_r;
    logic        core_ack_r, done_r;
    logic [23:0] core_rdata_r;
    // Engine
    bma_eng_t    eng_r;
    logic [23:0] asm_r;
    logic [1:0]  bidx_r;

    wire host_s  = host_s_r[1];
    wire breq_s  = !breq_s_r[1];
    wire bma_fmt_t fmt = bma_fmt_t'(bctl_r[FMT_LSB +: 2]);
    wire store   = bctl_r[DIR_BIT];
    wire [1:0] nbytes = bma_bytes_per_word(fmt);

    // Register port decode
    wire wr_sys  = reg_en && reg_we && (reg_addr == SYSCTL_ADDR);
    wire wr_iow  = reg_en && reg_we && (reg_addr == IOWAIT_ADDR);
    wire wr_cms  = reg_en && reg_we && (reg_addr == CMSEN_ADDR);
    wire wr_bctl = reg_en && reg_we && (reg_addr == BCTL_ADDR);
    wire wr_bint = reg_en && reg_we && (reg_addr == BINT_ADDR);
    wire wr_bext = reg_en && reg_we && (reg_addr == BEXT_ADDR);
    wire wr_bcnt = reg_en && reg_we && (reg_addr == BCNT_ADDR);
    wire [15:0] rd_mux =
        (reg_addr == SYSCTL_ADDR) ? sysctl_r :
        (reg_addr == IOWAIT_ADDR) ? iowait_r :
        (reg_addr == CMSEN_ADDR)  ? {12'h000, cmsen_r} :
        (reg_addr == BCTL_ADDR)   ? {page_r, bctl_r[7:0]} :
        (reg_addr == BINT_ADDR)   ? {2'b00, int_addr_r} :
        (reg_addr == BEXT_ADDR)   ? {2'b00, ext_addr_r} :
        (reg_addr == BCNT_ADDR)   ? {2'b00, wcount_r} : 16'h0000;

    // Wait-state selection per space
    wire wmode = sysctl_r[WMODE_BIT];
    wire [1:0] io_region = core_cmd.addr[IO_REGION_LSB +: 2];
    wire [3:0] io_n = iowait_r[{io_region, 2'b00} +: 4];
    wire [3:0] core_n =
        (core_cmd.space == SP_PM) ? sysctl_r[PROGRAM_SPACE_WAIT_LSB +: 4] :
        (core_cmd.space == SP_DM) ? sysctl_r[DATA_SPACE_WAIT_LSB +: 4] :
        (core_cmd.space == SP_IO) ? io_n : sysctl_r[BWAIT_LSB +: 4];
    wire [3:0] core_ws = bma_wait_states(core_n, wmode);
    wire [3:0] byte_ws = bma_wait_states(sysctl_r[BWAIT_LSB +: 4], wmode);

    // Arbitration: core first, bus grant only between accesses
    wire a_idle    = !act_r && !grant_r;
    wire take_core = a_idle && core_req && !breq_s;
    wire take_byte = a_idle && !core_req && !breq_s && (eng_r == E_BYTES);
    wire take      = take_core || take_byte;
    wire [3:0] ws  = take_core ? core_ws : byte_ws;
    wire       last;

    bma_wait_cnt #(.W(5)) u_wait (
        .clk  (clk),
        .rstn (rstn),
        .load (take),
        .len  ({1'b0, ws} + BASE_CYC),
        .last (last)
    );

    wire byte_fin = act_r && last && !act_core_r;
    wire [13:0] ext_next = ext_addr_r + 14'd1;
    wire [7:0]  byte_rd  = din_s2_r[15:8];
    wire [23:0] asm_nxt  = {asm_r[15:0], byte_rd};
    wire [23:0] word_in  =
        (fmt == FMT_DM8_HI) ? {8'h00, asm_r[7:0], 8'h00} :
        (fmt == FMT_DM8_LO) ? {16'h0000, asm_r[7:0]} :
        (fmt == FMT_DM16)   ? {8'h00, asm_r[15:0]} : asm_r;
    wire [7:0] byte_out =
        (fmt == FMT_DM8_LO) ? asm_r[7:0] :
        (fmt == FMT_DM8_HI) ? asm_r[15:8] :
        (fmt == FMT_DM16)   ? asm_r[23:16] : asm_r[23:16];
    wire [23:0] fetch_al = (fmt == FMT_DM16) ? {mem_rd_data[15:0], 8'h00} : mem_rd_data;

    wire buf_in_valid = (eng_r == E_PUSH);
    wire buf_in_ready;
    wire pushed = buf_in_valid && buf_in_ready;
    wire fetched = mem_rd_valid && mem_rd_ready;
    wire word_end = pushed || (byte_fin && store && (bidx_r == nbytes - 2'd1));

    bma_buf2 #(.W($bits(bma_mem_word_t))) u_buf (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   ({(fmt == FMT_PM24), int_addr_r, word_in}),
        .out_valid (mem_wr_valid),
        .out_ready (mem_wr_ready),
        .out_data  (mem_wr_word)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            din_s1_r <= '0;
            din_s2_r <= '0;
            host_s_r <= 2'b00;
            breq_s_r <= 2'b11;
        end else begin
            din_s1_r <= data_i;
            din_s2_r <= din_s1_r;
            host_s_r <= {host_s_r[0], host_mode};
            breq_s_r <= {breq_s_r[0], bus_req_n};
        end
    end

    // Registers; hardware updates of address and count win over software writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sysctl_r    <= SYSCTL_RST;
            iowait_r    <= IOWAIT_RST;
            cmsen_r     <= CMSEN_RST;
            bctl_r      <= BCTL_RST;
            page_r      <= '0;
            int_addr_r  <= '0;
            ext_addr_r  <= '0;
            wcount_r    <= '0;
            reg_rdata_r <= '0;
        end else begin
            if (wr_sys)  sysctl_r <= reg_wdata;
            if (wr_iow)  iowait_r <= reg_wdata;
            if (wr_cms)  cmsen_r  <= reg_wdata[3:0];
            if (wr_bctl) bctl_r   <= reg_wdata;
            if (reg_en && !reg_we) reg_rdata_r <= rd_mux;
            if (byte_fin) begin
                ext_addr_r <= ext_next;
                page_r     <= page_r + {7'h00, (ext_next == 14'h0000)};
            end else begin
                if (wr_bext) ext_addr_r <= reg_wdata[13:0];
                if (wr_bctl) page_r     <= reg_wdata[PAGE_LSB +: 8];
            end
            if (word_end) begin
                int_addr_r <= int_addr_r + 14'd1;
                wcount_r   <= wcount_r - 14'd1;
            end else begin
                if (wr_bint) int_addr_r <= reg_wdata[13:0];
                if (wr_bcnt) wcount_r   <= reg_wdata[13:0];
            end
        end
    end

    // Byte transfer engine
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            eng_r  <= E_IDLE;
            asm_r  <= '0;
            bidx_r <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (eng_r)
                E_IDLE: begin
                    bidx_r <= '0;
                    if (wr_bcnt && reg_wdata[13:0] != 14'h0000) begin
                        eng_r <= store ? E_FETCH : E_BYTES;
                    end
                end
                E_FETCH: begin
                    if (fetched) begin
                        asm_r <= fetch_al;
                        eng_r <= E_BYTES;
                    end
                end
                E_BYTES: begin
                    if (byte_fin) begin
                        asm_r  <= store ? {asm_r[15:0], 8'h00} : asm_nxt;
                        bidx_r <= bidx_r + 2'd1;
                        if (bidx_r == nbytes - 2'd1) begin
                            bidx_r <= '0;
                            if (!store) begin
                                eng_r <= E_PUSH;
                            end else if (wcount_r == 14'd1) begin
                                eng_r  <= E_IDLE;
                                done_r <= 1'b1;
                            end else begin
                                eng_r <= E_FETCH;
                            end
                        end
                    end
                end
                E_PUSH: begin
                    if (pushed) begin
                        eng_r  <= (wcount_r == 14'd1) ? E_IDLE : E_BYTES;
                        done_r <= (wcount_r == 14'd1);
                    end
                end
                default: eng_r <= E_IDLE;
            endcase
        end
    end

    // Access machine; selects and strobes held for the whole counted length
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            act_r        <= 1'b0;
            act_core_r   <= 1'b0;
            grant_r      <= 1'b0;
            sel_r        <= '0;
            rd_r         <= 1'b0;
            wr_r         <= 1'b0;
            addr_r       <= '0;
            dout_r       <= '0;
            lane_oe_n_r  <= 3'b111;
            core_ack_r   <= 1'b0;
            core_rdata_r <= '0;
        end else begin
            core_ack_r <= 1'b0;
            grant_r    <= breq_s && !act_r;
            if (take) begin
                act_r      <= 1'b1;
                act_core_r <= take_core;
                sel_r      <= take_core ? (4'b0001 << core_cmd.space) : 4'b1000;
                rd_r       <= take_core ? !core_cmd.we : !store;
                wr_r       <= take_core ? core_cmd.we : store;
                addr_r     <= take_core ? core_cmd.addr : ext_addr_r;
                dout_r     <= take_core ? core_cmd.wdata :
                              {page_r, byte_out, 8'h00};
                lane_oe_n_r <= take_core ? {3{!core_cmd.we}} :
                               {1'b0, !store, 1'b1};
            end else if (act_r && last) begin
                act_r       <= 1'b0;
                sel_r       <= '0;
                rd_r        <= 1'b0;
                wr_r        <= 1'b0;
                lane_oe_n_r <= 3'b111;
                if (act_core_r) begin
                    core_ack_r   <= 1'b1;
                    core_rdata_r <= din_s2_r;
                end
            end
        end
    end

    // sel_r bit order follows bma_space_t: PM, DM, IO, BYTE
    wire [3:0] sel_en = {cmsen_r[CMS_BYTE], cmsen_r[CMS_IO], cmsen_r[CMS_DM], cmsen_r[CMS_PM]};
    assign pms_n        = !sel_r[0];
    assign dms_n        = !sel_r[1];
    assign io_space_select_n       = !sel_r[2];
    assign bms_n        = !sel_r[3];
    assign cms_n        = !(|(sel_r & sel_en));
    assign rd_n         = !rd_r;
    assign wr_n         = !wr_r;
    assign addr_o       = addr_r;
    assign data_o       = dout_r;
    assign data_oe_n    = grant_r ? 3'b111 : lane_oe_n_r;
    assign ctrl_oe_n    = grant_r;
    assign addr_lo_oe_n = grant_r;
    assign addr_hi_oe_n = grant_r || host_s;
    assign bus_grant_n  = !grant_r;
    assign core_ack     = core_ack_r;
    assign core_rdata   = core_rdata_r;
    assign mem_rd_valid = (eng_r == E_FETCH);
    assign mem_rd_addr  = {(fmt == FMT_PM24), int_addr_r};
    assign reg_rdata    = reg_rdata_r;
    assign byte_transfer_engine_busy    = (eng_r != E_IDLE);
    assign byte_transfer_engine_done    = done_r;

    // Checks
    logic [4:0] hold_cnt_r, hold_len_r;
    logic [1:0] bytes_seen_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_cnt_r   <= '0;
            hold_len_r   <= '0;
            bytes_seen_r <= '0;
        end else begin
            hold_cnt_r   <= take ? 5'd0 : (act_r ? hold_cnt_r + 5'd1 : 5'd0);
            if (take) hold_len_r <= {1'b0, ws} + BASE_CYC;
            bytes_seen_r <= (pushed || eng_r == E_IDLE) ? 2'd0 : bytes_seen_r + {1'b0, byte_fin};
        end
    end

    chk_hold_length: assert property (@(posedge clk) disable iff (!rstn)
        $fell(act_r) |-> hold_cnt_r == hold_len_r) else $error("strobe length wrong");
    chk_cms_follow: assert property (@(posedge clk) disable iff (!rstn)
        (!bms_n && cmsen_r[CMS_BYTE]) || (!pms_n && cmsen_r[CMS_PM])
        || (!io_space_select_n && cmsen_r[CMS_IO]) |-> !cms_n) else $error("composite select missing");
    chk_cms_reset: assert property (@(posedge clk)
        $rose(rstn) |-> cmsen_r == 4'hb) else $error("composite enables reset wrong");
    chk_host_addr: assert property (@(posedge clk) disable iff (!rstn)
        host_s |-> addr_hi_oe_n && (addr_lo_oe_n == grant_r)) else $error("host mode address");
    chk_core_first: assert property (@(posedge clk) disable iff (!rstn)
        core_req && a_idle && !breq_s |=> act_r && act_core_r) else $error("core lost priority");
    chk_byte_lanes: assert property (@(posedge clk) disable iff (!rstn)
        !bms_n && !grant_r |-> !data_oe_n[2] && data_o[23:16] == page_r) else $error("byte page lane");
    chk_word_bytes: assert property (@(posedge clk) disable iff (!rstn)
        pushed |-> bytes_seen_r == nbytes) else $error("byte count per word");
    chk_zero_fill: assert property (@(posedge clk) disable iff (!rstn)
        pushed && fmt == FMT_DM8_LO |-> word_in[23:8] == 16'h0000) else $error("low format fill");
    chk_done_count: assert property (@(posedge clk) disable iff (!rstn)
        byte_transfer_engine_done |-> wcount_r == 14'd0 && $past(byte_transfer_engine_busy)) else $error("done without zero count");
    chk_io_wait: assert property (@(posedge clk) disable iff (!rstn)
        take_core && core_cmd.space == SP_IO && !wmode && core_cmd.addr[10:9] == 2'd3
        |=> hold_len_r == {1'b0, iowait_r[15:12]} + BASE_CYC) else $error("io region wait");

    cov_load_done: cover property (@(posedge clk) disable iff (!rstn) byte_transfer_engine_done && !store);
    cov_store_done: cover property (@(posedge clk) disable iff (!rstn) byte_transfer_engine_done && store);
    cov_core_clash: cover property (@(posedge clk) disable iff (!rstn)
        take_core && eng_r == E_BYTES);
    cov_buf_full: cover property (@(posedge clk) disable iff (!rstn) buf_in_valid && !buf_in_ready);
endmodule

// ===== rtl/bma_pkg.sv
// Package with register map, field layout, types and timing for the byte-memory DMA block
package bma_pkg;
    // Register offsets in on-chip data memory space
    localparam logic [13:0] SYSCTL_ADDR = 14'h3fff;
    localparam logic [13:0] IOWAIT_ADDR = 14'h3ffe;
    localparam logic [13:0] CMSEN_ADDR  = 14'h3fe6;
    localparam logic [13:0] BCTL_ADDR   = 14'h3fe3;
    localparam logic [13:0] BINT_ADDR   = 14'h3fe1;
    localparam logic [13:0] BEXT_ADDR   = 14'h3fe2;
    localparam logic [13:0] BCNT_ADDR   = 14'h3fe4;
    // System control fields
    localparam int PROGRAM_SPACE_WAIT_LSB = 0;
    localparam int DATA_SPACE_WAIT_LSB = 4;
    localparam int BWAIT_LSB = 8;
    localparam int WMODE_BIT = 12;
    // Byte transfer control fields
    localparam int FMT_LSB   = 0;
    localparam int DIR_BIT   = 2;
    localparam int PAGE_LSB  = 8;
    // Composite select enable bit positions
    localparam int CMS_PM    = 0;
    localparam int CMS_DM    = 1;
    localparam int CMS_BYTE  = 2;
    localparam int CMS_IO    = 3;
    // Values after reset
    localparam logic [15:0] SYSCTL_RST = 16'h0407;
    localparam logic [15:0] IOWAIT_RST = 16'h0000;
    localparam logic [3:0]  CMSEN_RST  = 4'hb;
    localparam logic [15:0] BCTL_RST   = 16'h0000;
    // I/O region is picked by address bits 10:9
    localparam int IO_REGION_LSB = 9;
    localparam logic [3:0] WAIT_MAX = 4'hf;
    // Base strobe cycles: one access cycle plus two for the data input synchroniser
    localparam logic [4:0] BASE_CYC = 5'h03;

    typedef enum logic [1:0] {
        SP_PM   = 2'b00,
        SP_DM   = 2'b01,
        SP_IO   = 2'b10,
        SP_BYTE = 2'b11
    } bma_space_t;

    typedef enum logic [1:0] {
        FMT_PM24   = 2'b00,
        FMT_DM16   = 2'b01,
        FMT_DM8_HI = 2'b10,
        FMT_DM8_LO = 2'b11
    } bma_fmt_t;

    typedef struct packed {
        bma_space_t  space;
        logic        we;
        logic [13:0] addr;
        logic [23:0] wdata;
    } bma_ext_req_t;

    typedef struct packed {
        logic        pm;
        logic [13:0] addr;
        logic [23:0] data;
    } bma_mem_word_t;

    // 2N+1 mode saturates at the top of the 0..15 range
    function automatic logic [3:0] bma_wait_states(input logic [3:0] n, input logic mode);
        if (!mode) begin
            return n;
        end
        return (n > 4'h7) ? WAIT_MAX : {n[2:0], 1'b1};
    endfunction

    function automatic logic [1:0] bma_bytes_per_word(input bma_fmt_t fmt);
        case (fmt)
            FMT_PM24: return 2'd3;
            FMT_DM16: return 2'd2;
            default:  return 2'd1;
        endcase
    endfunction
endpackage

// ===== rtl/bma_wait_cnt.sv
// Down counter that times one external access strobe
`timescale 1ns/1ps
module bma_wait_cnt #(
    parameter int W = 5
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         load,
    input  wire logic [W-1:0] len,
    output logic              last
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= len;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
        end
    end

    assign last = (cnt_r == W'(1)) && !load;
endmodule

// ===== rtl/bma_buf2.sv
// Two-entry valid/ready buffer for assembled on-chip words
`timescale 1ns/1ps
module bma_buf2 #(
    parameter int W = 39
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] mem_r [2];
    logic         wp_r;
    logic         rp_r;
    logic [1:0]   cnt_r;
    wire          push = in_valid && in_ready;
    wire          pop  = out_valid && out_ready;

    assign in_ready  = (cnt_r != 2'd2);
    assign out_valid = (cnt_r != 2'd0);
    assign out_data  = mem_r[rp_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'd0;
        end else begin
            wp_r  <= wp_r ^ push;
            rp_r  <= rp_r ^ pop;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ===== tb/bma_byte_mem.sv
// Byte-wide external memory model on the byte select
`timescale 1ns/1ps
module bma_byte_mem (
    input  wire logic        clk,
    input  wire logic        sel_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [13:0] addr,
    input  wire logic [23:0] dout,
    output logic [23:0]      din
);
    logic [7:0] mem [64];
    logic [7:0] last = 8'h00;
    wire        rd = !sel_n && !rd_n;
    initial for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'ha5;
    // Idle lanes show the inverse of the last byte so a stale value never passes
    assign din = {~last, rd ? mem[addr[5:0]] : ~last, ~last};
    always @(posedge clk) begin
        if (rd) last <= mem[addr[5:0]];
        if (!sel_n && !wr_n) mem[addr[5:0]] <= dout[15:8];
    end
endmodule

// ===== tb/bma_tb_top.sv
// Bench: registers, I/O wait states, selects and byte transfers
`timescale 1ns/1ps
module bma_tb_top;
    import bma_pkg::*;
    logic          clk, rstn, reg_en, reg_we, core_req, core_ack, rd_n, wr_n;
    logic          bms_n, io_space_select_n, cms_n, wv, wrdy, done, host, hi_oe_n;
    logic [13:0]   reg_addr, addr_o;
    logic [15:0]   reg_wdata, reg_rdata;
    logic [23:0]   data_o, data_i;
    bma_ext_req_t  core_cmd;
    bma_mem_word_t word;
    int            err_total, cmp_count, cyc;
    bma_top bma_top_i (.clk(clk), .rstn(rstn), .reg_en(reg_en), .reg_we(reg_we),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .core_req(core_req), .core_cmd(core_cmd), .core_ack(core_ack), .core_rdata(),
        .host_mode(host), .bus_req_n(1'b1), .bus_grant_n(), .addr_o(addr_o),
        .addr_lo_oe_n(), .addr_hi_oe_n(hi_oe_n), .data_o(data_o), .data_i(data_i),
        .data_oe_n(), .ctrl_oe_n(), .rd_n(rd_n), .wr_n(wr_n), .pms_n(), .dms_n(),
        .bms_n(bms_n), .io_space_select_n(io_space_select_n), .cms_n(cms_n), .mem_wr_valid(wv),
        .mem_wr_ready(wrdy), .mem_wr_word(word), .mem_rd_valid(),
        .mem_rd_ready(1'b1), .mem_rd_addr(), .mem_rd_data(24'h5a3c96),
        .byte_transfer_engine_busy(), .byte_transfer_engine_done(done));
    bma_byte_mem bma_byte_mem_i (.clk(clk), .sel_n(bms_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr_o), .dout(data_o), .din(data_i));
    task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rg(logic we, logic [13:0] a, logic [15:0] d);
        @(posedge clk);
        reg_en    <= 1'b1;
        reg_we    <= we;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_en <= 1'b0;
        #1;
    endtask
    task automatic wt(bit on_done);
        int n = 0;
        while ((on_done ? done : wv) !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic core_io(logic [13:0] a, int exp_n);
        int n = 0;
        @(posedge clk);
        core_req <= 1'b1;
        core_cmd <= '{SP_IO, 1'b0, a, 24'h0};
        @(posedge clk);
        #1;
        while (core_ack !== 1'b1 && n < 40) begin
            chk("io and composite select", 24'h0, {22'h0, io_space_select_n, cms_n});
            @(posedge clk);
            #1;
            n++;
        end
        core_req <= 1'b0;
        chk("io strobe cycles", 24'(exp_n), 24'(n));
    endtask
    task automatic setup(bma_fmt_t f, logic [15:0] cnt, bit st);
        rg(1, BCTL_ADDR, {13'h0, st, f});
        rg(1, BINT_ADDR, 16'h0010);
        rg(1, BEXT_ADDR, 16'h0004);
        rg(1, BCNT_ADDR, cnt);
    endtask
    task automatic xfer(bma_fmt_t f, logic [23:0] exp);
        setup(f, 16'h0001, 1'b0);
        wt(0);
        chk("word", exp, word.data);
        chk("pm and addr", {9'h0, f == FMT_PM24, 14'h0010}, {9'h0, word.pm, word.addr});
        chk("done", 24'h1, {23'h0, done});
    endtask
    task automatic t_regs;
        host <= 1'b1;
        rg(0, SYSCTL_ADDR, 16'h0000);
        chk("sysctl", 24'h000407, {8'h0, reg_rdata});
        rg(0, CMSEN_ADDR, 16'h0000);
        chk("enables", 24'hf & ~(24'h1 << CMS_BYTE), {8'h0, reg_rdata});
        chk("host upper address oe", 24'h1, {23'h0, hi_oe_n});
        host <= 1'b0;
        rg(1, 14'h0000, 16'hffff);
        rg(0, 14'h0000, 16'h0000);
        chk("unmapped", 24'h0, {8'h0, reg_rdata});
        $display("test regs done");
    endtask
    task automatic t_io;
        rg(1, IOWAIT_ADDR, 16'hf200);
        core_io(14'h01ff, 3);
        chk("full upper address oe", 24'h0, {23'h0, hi_oe_n});
        core_io(14'h0200, 3);
        core_io(14'h0400, 5);
        core_io(14'h07ff, 18);
        rg(1, SYSCTL_ADDR, 16'h1407);
        core_io(14'h0400, 8);
        core_io(14'h0000, 4);
        rg(1, SYSCTL_ADDR, 16'h0407);
        $display("test io done");
    endtask
    task automatic t_fmt;
        xfer(FMT_PM24, 24'ha1a0a3);
        xfer(FMT_DM16, 24'h00a1a0);
        xfer(FMT_DM8_HI, 24'h00a100);
        xfer(FMT_DM8_LO, 24'h0000a1);
        $display("test formats done");
    endtask
    task automatic t_stall;
        @(posedge clk);
        wrdy <= 1'b0;
        setup(FMT_DM8_LO, 16'h0002, 1'b0);
        wt(1);
        repeat (3) @(posedge clk);
        @(posedge clk);
        wrdy <= 1'b1;
        #1;
        chk("held word 0", 24'h0000a1, wv ? word.data : 24'hx);
        @(posedge clk);
        #1;
        chk("held word 1", 24'h0000a0, wv ? word.data : 24'hx);
        @(posedge clk);
        #1;
        chk("drained", 24'h0, {23'h0, wv});
        $display("test stall done");
    endtask
    // Store path: the on-chip word comes from the tied read data, MSB byte first
    task automatic t_store;
        setup(FMT_DM16, 16'h0001, 1'b1);
        wt(1);
        chk("store done", 24'h1, {23'h0, done});
        chk("stored byte 0", 24'h3c, {16'h0, bma_byte_mem_i.mem[4]});
        chk("stored byte 1", 24'h96, {16'h0, bma_byte_mem_i.mem[5]});
        $display("test store done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Generous ceiling: the whole sequence needs well under two thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        {rstn, reg_en, reg_we, core_req, wrdy, host} = 6'b000010;
        {reg_addr, reg_wdata, core_cmd} = '0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_io();
        t_fmt();
        t_stall();
        t_store();
        end_of_test();
    end
endmodule
